// ===== hw/cmd_word_if.sv
// carrier for one host command word from the link domain to the core
// assumes the word is stable whenever the toggle has changed
`timescale 1ns/1ns
interface cmd_word_if;
  logic [15:0] word;
  logic        tog;
  modport link (output word, output tog);
  modport core (input word, input tog);
endinterface : cmd_word_if

// ===== hw/cmd_word_rx.sv
// shift register for 16-bit host words, running on the link clock
// assumes the link clock only toggles while the chip select is low
`timescale 1ns/1ns
module cmd_word_rx (
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  input  wire logic sys_rst,
  cmd_word_if.link  cw
);

  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic [15:0] sh_q;
  logic [15:0] sh_d;
  logic [15:0] word_q;
  logic [15:0] word_d;
  logic        tog_q;
  logic        tog_d;

  // ----------------------------------------------------------------
  // word assembly
  // ----------------------------------------------------------------
  // msb first; the 16th bit publishes the word and flips the toggle
  always_comb begin
    bit_d  = bit_q + 4'h1;
    sh_d   = {sh_q[14:0], spi_mosi};
    word_d = word_q;
    tog_d  = tog_q;
    if (bit_q == 4'hf) begin
      word_d = sh_d;
      tog_d  = ~tog_q;
    end
  end

  // the frame's own select clears the bit count, so no edge after the frame is needed
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_q <= 4'h0;
    end else begin
      bit_q <= bit_d;
    end
  end

  // published word and toggle survive the frame for the core to pick up
  always_ff @(posedge spi_sclk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_q   <= 16'h0000;
      word_q <= 16'h0000;
      tog_q  <= 1'b0;
    end else begin
      sh_q   <= sh_d;
      word_q <= word_d;
      tog_q  <= tog_d;
    end
  end

  assign cw.word = word_q;
  assign cw.tog  = tog_q;

endmodule : cmd_word_rx

// ===== hw/supply_supervisor.sv
// mode, regulator and fail-safe control of the supply supervisor
// assumes analog comparators upstream deliver pin levels, and that
// go_normal, go_low_power, ack_fail and wd_refresh come from mclk logic
`timescale 1ns/1ns
module supply_supervisor #(
  parameter int unsigned BUS_IDLE_CYC  = supply_supervisor_pkg::BUS_IDLE_CYC,
  parameter int unsigned WD_PERIOD_CYC = supply_supervisor_pkg::WD_PERIOD_CYC,
  parameter int unsigned RST_PULSE_CYC = supply_supervisor_pkg::RST_PULSE_CYC,
  parameter int unsigned RST_SHORT_CYC = supply_supervisor_pkg::RST_SHORT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  input  wire logic        battery_supply_in,
  input  wire logic        battery_por_in,
  input  wire logic        vdd_low_in,
  input  wire logic        rst_line_low_in,
  input  wire logic        bus_activity_in,
  input  wire logic        lin_activity_in,
  input  wire logic        sense1_in,
  input  wire logic [1:0]  strap_select_pin,
  input  wire logic [7:0]  wd_init_cfg,
  input  wire logic [2:0]  misc_init_cfg,
  input  wire logic        wake_bus_en,
  input  wire logic        wake_lin_en,
  input  wire logic        wake_sense_en,
  input  wire logic        cyclic_int_sel,
  input  wire logic        go_normal,
  input  wire logic        go_low_power,
  input  wire logic        ack_fail,
  input  wire logic        wd_refresh,
  output logic             vdd_reg_en,
  output logic             rst_n_out,
  output logic             safe_n_out,
  output logic             cyclic_int_en,
  output logic             battery_fail_flag,
  output logic [6:0]       mode_out,
  output logic [1:0]       safe_beh_out,
  output logic             regulator_off_safe
);

  localparam int unsigned W = supply_supervisor_pkg::CNT_W;

  // ----------------------------------------------------------------
  // command word crossing
  // ----------------------------------------------------------------
  cmd_word_if cw ();

  cmd_word_rx u_rx (
    .spi_sclk (spi_sclk),
    .spi_cs_n (spi_cs_n),
    .spi_mosi (spi_mosi),
    .sys_rst  (sys_rst),
    .cw       (cw)
  );

  logic        tog_s1_q;
  logic        tog_s2_q;
  logic        tog_s3_q;
  logic        cmd_valid;
  logic        cmd_wake;
  logic        cmd_release;

  // the word is read only after the toggle is two flops deep, so it is long settled
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= cw.tog;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  assign cmd_valid   = tog_s2_q ^ tog_s3_q;
  assign cmd_wake    = cmd_valid && (cw.word == supply_supervisor_pkg::CMD_WAKE);
  assign cmd_release = cmd_valid && ((cw.word == supply_supervisor_pkg::CMD_SAFE_REL0) ||
                                     (cw.word == supply_supervisor_pkg::CMD_SAFE_REL1));

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NPIN = 9;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;

  assign pin_raw = {strap_select_pin, sense1_in, lin_activity_in, bus_activity_in,
                    rst_line_low_in, vdd_low_in, battery_por_in, battery_supply_in};

  // each pin passes two flops; only the second one is read
  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_s1_q[i] <= 1'b0;
          pin_s2_q[i] <= 1'b0;
        end else begin
          pin_s1_q[i] <= pin_raw[i];
          pin_s2_q[i] <= pin_s1_q[i];
        end
      end
    end
  endgenerate

  logic       batt_ok;
  logic       batt_por;
  logic       vdd_low;
  logic       rstl_low;
  logic       bus_act;
  logic       lin_act;
  logic       sense_hi;
  logic [1:0] strap;

  assign batt_ok  = pin_s2_q[0];
  assign batt_por = pin_s2_q[1];
  assign vdd_low  = pin_s2_q[2];
  assign rstl_low = pin_s2_q[3];
  assign bus_act  = pin_s2_q[4];
  assign lin_act  = pin_s2_q[5];
  assign sense_hi = pin_s2_q[6];
  assign strap    = pin_s2_q[8:7];

  // ----------------------------------------------------------------
  // behaviour selection
  // ----------------------------------------------------------------
  // returns {valid, behaviour}; codes outside the four leave the strap in charge
  function automatic logic [2:0] decode_ovr(input logic [2:0] code);
    logic [2:0] r;
    r = 3'h0;
    case (code)
      supply_supervisor_pkg::OVR_A:     r = {1'b1, supply_supervisor_pkg::BEH_A};
      supply_supervisor_pkg::OVR_IDLE:  r = {1'b1, supply_supervisor_pkg::BEH_IDLE};
      supply_supervisor_pkg::OVR_INLOW: r = {1'b1, supply_supervisor_pkg::BEH_INLOW};
      supply_supervisor_pkg::OVR_BOTH:  r = {1'b1, supply_supervisor_pkg::BEH_BOTH};
      default:                          r = 3'h0;
    endcase
    return r;
  endfunction : decode_ovr

  supply_supervisor_pkg::safe_beh_t strap_beh_q;
  supply_supervisor_pkg::safe_beh_t strap_beh_d;
  supply_supervisor_pkg::safe_beh_t eff_beh;
  logic [2:0] ovr;

  assign ovr     = decode_ovr(misc_init_cfg);
  assign eff_beh = ovr[2] ? supply_supervisor_pkg::safe_beh_t'(ovr[1:0]) : strap_beh_q;

  // ----------------------------------------------------------------
  // event monitors
  // ----------------------------------------------------------------
  logic [W-1:0] idle_q;
  logic [W-1:0] idle_d;
  logic         idle_exp;
  logic         sense_prev_q;
  logic         sense_fell_q;
  logic         sense_fell_d;
  logic         sense_low;

  assign idle_exp  = (idle_q == W'(BUS_IDLE_CYC - 1));
  assign sense_low = sense_fell_q;

  // idle timer restarts on any bus traffic and saturates at expiry
  always_comb begin
    idle_d = idle_exp ? idle_q : idle_q + W'(1);
    if (bus_act) begin
      idle_d = '0;
    end
    sense_fell_d = sense_fell_q;
    if (sense_prev_q && !sense_hi) begin
      sense_fell_d = 1'b1;
    end else if (sense_hi) begin
      sense_fell_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_q       <= '0;
      sense_prev_q <= 1'b0;
      sense_fell_q <= 1'b0;
    end else begin
      idle_q       <= idle_d;
      sense_prev_q <= sense_hi;
      sense_fell_q <= sense_fell_d;
    end
  end

  // ----------------------------------------------------------------
  // mode, watchdog and safe machine
  // ----------------------------------------------------------------
  supply_supervisor_pkg::mode_t mode_q;
  supply_supervisor_pkg::mode_t mode_d;
  logic [W-1:0] wd_q;
  logic [W-1:0] wd_d;
  logic [W-1:0] pulse_q;
  logic [W-1:0] pulse_d;
  logic [W-1:0] rshort_q;
  logic [W-1:0] rshort_d;
  logic [3:0]   fails_q;
  logic [3:0]   fails_d;
  logic         safe_n_q;
  logic         safe_n_d;
  logic         rst_n_q;
  logic         rst_n_d;
  logic         soff_q;
  logic         soff_d;
  logic         reg_q;
  logic         reg_d;
  logic         bf_q;
  logic         bf_d;
  logic         hold_q;
  logic         wd_run;
  logic         wd_miss;
  logic         off_cond;
  logic         wake;
  logic         recovered;

  assign wd_run = (mode_q == supply_supervisor_pkg::ST_INIT) || (mode_q == supply_supervisor_pkg::ST_NPEND) ||
                  (mode_q == supply_supervisor_pkg::ST_NORMAL);
  assign wd_miss = wd_run && !wd_refresh && (wd_q == W'(WD_PERIOD_CYC - 1));
  assign wake = (bus_act && wake_bus_en) || (lin_act && wake_lin_en) || (sense_hi && wake_sense_en);
  assign recovered = !vdd_low && !rstl_low && wd_refresh;

  // which external condition lets a b behaviour drop the regulator
  always_comb begin
    case (eff_beh)
      supply_supervisor_pkg::BEH_IDLE:  off_cond = idle_exp;
      supply_supervisor_pkg::BEH_INLOW: off_cond = sense_low || !sense_hi;
      supply_supervisor_pkg::BEH_BOTH:  off_cond = idle_exp && (sense_low || !sense_hi);
      default:                          off_cond = 1'b0;
    endcase
  end

  // all mode moves; the safe output is released first so any new cause wins
  always_comb begin
    mode_d      = mode_q;
    wd_d        = wd_q;
    pulse_d     = pulse_q + W'(1);
    rshort_d    = '0;
    fails_d     = fails_q;
    safe_n_d    = safe_n_q;
    soff_d      = soff_q;
    strap_beh_d = strap_beh_q;
    if (cmd_release && (mode_q != supply_supervisor_pkg::ST_SAFE)) begin
      safe_n_d = 1'b1;
    end
    if (wd_refresh) begin
      wd_d    = '0;
      fails_d = 4'h0;
    end else if (wd_run) begin
      wd_d = (wd_q == W'(WD_PERIOD_CYC - 1)) ? '0 : wd_q + W'(1);
    end
    case (mode_q)
      supply_supervisor_pkg::ST_INIT_RST: begin
        if (pulse_q >= W'(RST_PULSE_CYC - 1)) begin
          mode_d = supply_supervisor_pkg::ST_INIT;
        end
      end
      supply_supervisor_pkg::ST_RESET: begin
        if (pulse_q >= W'(RST_PULSE_CYC - 1)) begin
          mode_d = supply_supervisor_pkg::ST_NPEND;
        end
      end
      supply_supervisor_pkg::ST_INIT: begin
        if (go_normal) begin
          mode_d      = supply_supervisor_pkg::ST_NORMAL;
          strap_beh_d = supply_supervisor_pkg::safe_beh_t'(strap);
        end
      end
      supply_supervisor_pkg::ST_NPEND: begin
        if (go_normal) begin
          mode_d = supply_supervisor_pkg::ST_NORMAL;
        end
      end
      supply_supervisor_pkg::ST_NORMAL: begin
        if (go_low_power) begin
          mode_d = supply_supervisor_pkg::ST_LP_ON;
        end
      end
      supply_supervisor_pkg::ST_LP_ON: begin
        if (cmd_wake) begin
          mode_d = supply_supervisor_pkg::ST_NPEND;
        end else if (ack_fail) begin
          mode_d  = supply_supervisor_pkg::ST_RESET;
          pulse_d = '0;
        end
      end
      supply_supervisor_pkg::ST_SAFE: begin
        safe_n_d = 1'b0;
        if (soff_q) begin
          if (wake) begin
            soff_d  = 1'b0;
            mode_d  = supply_supervisor_pkg::ST_RESET;
            pulse_d = '0;
          end
        end else if (recovered) begin
          mode_d  = supply_supervisor_pkg::ST_NPEND;
          fails_d = 4'h0;
        end else if (off_cond) begin
          soff_d = 1'b1;
        end
      end
      default: mode_d = supply_supervisor_pkg::ST_INIT_RST;
    endcase
    // a missed refresh period costs one strike and one reset pulse; the miss reaching WD_FAIL_LIMIT enters safe mode with no pulse
    if (wd_miss) begin
      fails_d = fails_q + 4'h1;
      pulse_d = '0;
      mode_d  = (mode_q == supply_supervisor_pkg::ST_INIT) ? supply_supervisor_pkg::ST_INIT_RST :
                supply_supervisor_pkg::ST_RESET;
      if (fails_d >= (wd_init_cfg[supply_supervisor_pkg::SAFE_SEL_POS] ? 4'h2 : 4'h1)) begin
        safe_n_d = 1'b0;
      end
      if (fails_d == supply_supervisor_pkg::WD_FAIL_LIMIT) begin
        mode_d   = supply_supervisor_pkg::ST_SAFE;
        safe_n_d = 1'b0;
      end
    end
    // the line held low while we release it means an external short
    if (rstl_low && rst_n_q && (mode_q != supply_supervisor_pkg::ST_SAFE)) begin
      rshort_d = rshort_q + W'(1);
      if (rshort_q == W'(RST_SHORT_CYC - 1)) begin
        mode_d   = supply_supervisor_pkg::ST_SAFE;
        safe_n_d = 1'b0;
      end
    end
    // supply low forces reset outside safe mode; safe low goes out on the very same edge
    if (vdd_low && (mode_q != supply_supervisor_pkg::ST_SAFE)) begin
      mode_d   = (mode_q == supply_supervisor_pkg::ST_INIT_RST || mode_q == supply_supervisor_pkg::ST_INIT) ?
                 supply_supervisor_pkg::ST_INIT_RST : supply_supervisor_pkg::ST_RESET;
      pulse_d  = '0;
      safe_n_d = 1'b0;
    end
    rst_n_d = !((mode_d == supply_supervisor_pkg::ST_RESET) || (mode_d == supply_supervisor_pkg::ST_INIT_RST));
  end

  // regulator: hold bit chooses which supply event may switch it off
  always_comb begin
    reg_d = reg_q;
    bf_d  = bf_q;
    if (hold_q && batt_por) begin
      reg_d = 1'b0;
      bf_d  = 1'b1;
    end else if (!hold_q && !rst_n_d && !batt_ok) begin
      reg_d = 1'b0;
    end else if (soff_d) begin
      reg_d = 1'b0;
    end else if (batt_ok && !bf_q) begin
      reg_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q      <= supply_supervisor_pkg::ST_INIT_RST;
      wd_q        <= '0;
      pulse_q     <= '0;
      rshort_q    <= '0;
      fails_q     <= 4'h0;
      safe_n_q    <= 1'b1;
      rst_n_q     <= 1'b0;
      soff_q      <= 1'b0;
      reg_q       <= 1'b0;
      bf_q        <= 1'b0;
      hold_q      <= supply_supervisor_pkg::HOLD_RESET_VAL;
      strap_beh_q <= supply_supervisor_pkg::BEH_A;
    end else begin
      mode_q      <= mode_d;
      wd_q        <= wd_d;
      pulse_q     <= pulse_d;
      rshort_q    <= rshort_d;
      fails_q     <= fails_d;
      safe_n_q    <= safe_n_d;
      rst_n_q     <= rst_n_d;
      soff_q      <= soff_d;
      reg_q       <= reg_d;
      bf_q        <= bf_d;
      hold_q      <= wd_init_cfg[supply_supervisor_pkg::HOLD_BIT_POS];
      strap_beh_q <= strap_beh_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // cyclic interrupts stop the moment the mode is left, including after a bad acknowledge
  assign cyclic_int_en      = (mode_q == supply_supervisor_pkg::ST_LP_ON) && cyclic_int_sel;
  assign vdd_reg_en         = reg_q;
  assign rst_n_out          = rst_n_q;
  assign safe_n_out         = safe_n_q;
  assign battery_fail_flag  = bf_q;
  assign mode_out           = mode_q;
  assign safe_beh_out       = eff_beh;
  assign regulator_off_safe = soff_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_wake_word: assert property ((mode_q == supply_supervisor_pkg::ST_LP_ON) && cmd_wake && !vdd_low &&
    !wd_miss && !rstl_low |=> mode_q == supply_supervisor_pkg::ST_NPEND)
    else $error("wake word did not reach pending mode");
  a_ack_fail_rst: assert property ((mode_q == supply_supervisor_pkg::ST_LP_ON) && ack_fail && !cmd_wake
    |=> !rst_n_q && !cyclic_int_en)
    else $error("bad acknowledge did not reset");
  a_hold_por_off: assert property (hold_q && batt_por |=> !vdd_reg_en && battery_fail_flag)
    else $error("battery por with hold set left regulator on");
  a_safe_entry_low: assert property ($rose(mode_q == supply_supervisor_pkg::ST_SAFE) |-> !safe_n_out)
    else $error("safe mode entered with safe output high");
  a_inlow_reg_off: assert property ((mode_q == supply_supervisor_pkg::ST_SAFE) && !soff_q && !recovered &&
    (eff_beh == supply_supervisor_pkg::BEH_INLOW) && !sense_hi && !(hold_q && batt_por) ##1 1
    |-> ##1 !vdd_reg_en)
    else $error("sense low did not drop regulator");
  a_safe_held_low: assert property (!safe_n_out && !cmd_release |=> !safe_n_out)
    else $error("safe output released without release word");
  a_pulse_width: assert property ($rose(rst_n_out) && $past(mode_q) == supply_supervisor_pkg::ST_RESET
    |-> $past(pulse_q) >= W'(RST_PULSE_CYC - 1))
    else $error("reset pulse shorter than documented");
  a_recover_pend: assert property ((mode_q == supply_supervisor_pkg::ST_SAFE) && !soff_q && recovered
    |=> mode_q == supply_supervisor_pkg::ST_NPEND)
    else $error("recovery did not leave safe mode");
  a_vdd_low_both: assert property (vdd_low && (mode_q != supply_supervisor_pkg::ST_SAFE)
    |=> !rst_n_out && !safe_n_out)
    else $error("supply low did not drop reset and safe together");

  c_safe_entry: cover property ($rose(mode_q == supply_supervisor_pkg::ST_SAFE));
  c_safe_wake: cover property (soff_q ##1 !soff_q);
  c_safe_release: cover property (!safe_n_out ##1 safe_n_out);

endmodule : supply_supervisor

// ===== hw/supply_supervisor_pkg.sv
// constants, state and behaviour types of the fail-safe supply supervisor
// assumes a 25 mhz mclk and 16-bit host command words arriving on the link
package supply_supervisor_pkg;

  localparam int unsigned MCLK_KHZ       = 25000;
  localparam int unsigned BUS_IDLE_MS    = 8000;
  localparam int unsigned WD_PERIOD_MS   = 256;
  localparam int unsigned RST_PULSE_US   = 1000;
  localparam int unsigned RST_SHORT_MS   = 100;
  localparam int unsigned BUS_IDLE_CYC   = BUS_IDLE_MS * MCLK_KHZ;
  localparam int unsigned WD_PERIOD_CYC  = WD_PERIOD_MS * MCLK_KHZ;
  localparam int unsigned RST_PULSE_CYC  = RST_PULSE_US * MCLK_KHZ / 1000;
  localparam int unsigned RST_SHORT_CYC  = RST_SHORT_MS * MCLK_KHZ;
  localparam int unsigned CNT_W          = 28;
  localparam logic [3:0]  WD_FAIL_LIMIT  = 4'h8;

  localparam logic [15:0] CMD_WAKE       = 16'h5c10;
  localparam logic [15:0] CMD_SAFE_REL0  = 16'hdd00;
  localparam logic [15:0] CMD_SAFE_REL1  = 16'hdd80;

  localparam int unsigned HOLD_BIT_POS   = 0;
  localparam int unsigned SAFE_SEL_POS   = 4;
  localparam logic        HOLD_RESET_VAL = 1'b0;

  localparam logic [2:0]  OVR_A          = 3'h7;
  localparam logic [2:0]  OVR_IDLE       = 3'h6;
  localparam logic [2:0]  OVR_INLOW      = 3'h5;
  localparam logic [2:0]  OVR_BOTH       = 3'h4;

  typedef enum logic [1:0] {
    BEH_A    = 2'h0,
    BEH_IDLE = 2'h1,
    BEH_INLOW = 2'h2,
    BEH_BOTH = 2'h3
  } safe_beh_t;

  typedef enum logic [6:0] {
    ST_INIT_RST = 7'h01,
    ST_INIT     = 7'h02,
    ST_RESET    = 7'h04,
    ST_NPEND    = 7'h08,
    ST_NORMAL   = 7'h10,
    ST_LP_ON    = 7'h20,
    ST_SAFE     = 7'h40
  } mode_t;

endpackage : supply_supervisor_pkg

// ===== sim/fail_safe_supply_supervisor_bench.sv
// bench for the supply supervisor: modes, safe pin and regulator
// assumes short counts and the host link model on the link pins
`timescale 1ns/1ns
module fail_safe_supply_supervisor_bench;
  logic       mclk, sys_rst, battery_supply_in, battery_por_in, vdd_low_in, rst_line_low_in;
  logic       bus_activity_in, lin_activity_in, sense1_in, wake_bus_en, wake_lin_en, wake_sense_en;
  logic       cyclic_int_sel, spi_sclk, spi_cs_n, spi_mosi, vdd_reg_en, rst_n_out, safe_n_out;
  logic       cyclic_int_en, battery_fail_flag, regulator_off_safe;
  logic [1:0] strap_select_pin, safe_beh_out;
  logic [7:0] wd_init_cfg;
  logic [2:0] misc_init_cfg;
  logic [3:0] ctl;  // go_normal, go_low_power, ack_fail, wd_refresh
  logic [6:0] mode_out;
  int         bad_count, tests_run;
  wire  [9:0] st = {safe_n_out, rst_n_out, vdd_reg_en, mode_out};
  host_link_model host (.spi_sclk, .spi_cs_n, .spi_mosi);
  supply_supervisor #(.BUS_IDLE_CYC(400), .WD_PERIOD_CYC(2000), .RST_PULSE_CYC(10), .RST_SHORT_CYC(50)) uut (
    .mclk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_mosi, .battery_supply_in, .battery_por_in, .vdd_low_in,
    .rst_line_low_in, .bus_activity_in, .lin_activity_in, .sense1_in, .strap_select_pin, .wd_init_cfg,
    .misc_init_cfg, .wake_bus_en, .wake_lin_en, .wake_sense_en, .cyclic_int_sel, .go_normal(ctl[0]),
    .go_low_power(ctl[1]), .ack_fail(ctl[2]), .wd_refresh(ctl[3]), .vdd_reg_en, .rst_n_out, .safe_n_out,
    .cyclic_int_en, .battery_fail_flag, .mode_out, .safe_beh_out, .regulator_off_safe);
  // ----------------------------------------
  // clock, helpers and sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // inputs always move 2 ns after the edge, clear of sampling
  task step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : step
  task pulse(input int b);
    ctl[b] = 1'b1;
    step(1);
    ctl[b] = 1'b0;
  endtask : pulse
  task chk(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task complete_run;
    $display("mismatches %0d, checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // bounded wait on masked status; running out ends the run
  task wait_for(input logic [9:0] m, input logic [9:0] v, input int lim);
    for (int i = 0; i < lim && (st & m) !== v; i++) step(1);
    chk(st & m, v);
    if ((st & m) !== v) complete_run();
  endtask : wait_for
  initial begin
    {battery_por_in, vdd_low_in, rst_line_low_in, bus_activity_in, lin_activity_in} = 5'h00;
    {wake_bus_en, wake_lin_en, wake_sense_en, ctl, misc_init_cfg} = 10'h000;
    {battery_supply_in, sense1_in, cyclic_int_sel, sys_rst} = 4'hf;
    strap_select_pin = 2'h1;
    wd_init_cfg = 8'h10;
    step(12);
    chk({safe_n_out, rst_n_out, vdd_reg_en, battery_fail_flag}, 10'h008);
    sys_rst = 1'b0;
    wait_for(10'h080, 10'h080, 20);
    wait_for(10'h07f, 10'h002, 50);
    pulse(0);
    wait_for(10'h07f, 10'h010, 5);
    chk(safe_beh_out, 10'h001);
    for (int c = 4; c < 8; c++) begin
      misc_init_cfg = c[2:0];
      step(1);
      chk(safe_beh_out, 10'(7 - c));
    end
    misc_init_cfg = 3'h3;
    step(1);
    chk(safe_beh_out, 10'h001);
    misc_init_cfg = 3'h0;
    pulse(1);
    wait_for(10'h07f, 10'h020, 5);
    chk(cyclic_int_en, 10'h001);
    host.send(16'h5c10);
    wait_for(10'h07f, 10'h008, 20);
    pulse(0);
    cyclic_int_sel = 1'b0;
    pulse(1);
    chk({cyclic_int_en, mode_out}, 10'h020);
    cyclic_int_sel = 1'b1;
    pulse(2);
    wait_for(10'h100, 10'h000, 5);
    wait_for(10'h07f, 10'h008, 30);
    chk(cyclic_int_en, 10'h000);
    // no refresh from here: bit 4 set, so safe pin waits for the second miss
    for (int k = 0; k < 2; k++) begin
      wait_for(10'h100, 10'h000, 2100);
      step(5);
      chk(rst_n_out, 10'h000);
      wait_for(10'h100, 10'h100, 20);
      chk(safe_n_out, 10'(1 - k));
    end
    wait_for(10'h07f, 10'h040, 14000);
    wait_for(10'h080, 10'h000, 500);
    chk(regulator_off_safe, 10'h001);
    wake_bus_en = 1'b1;
    bus_activity_in = 1'b1;
    wait_for(10'h2ff, 10'h084, 10);
    bus_activity_in = 1'b0;
    wait_for(10'h07f, 10'h008, 30);
    host.send(16'hdd80);
    wait_for(10'h200, 10'h200, 20);
    misc_init_cfg = 3'h7;
    rst_line_low_in = 1'b1;
    step(40);
    chk(10'(mode_out), 10'h008);
    wait_for(10'h27f, 10'h040, 30);
    rst_line_low_in = 1'b0;
    sense1_in = 1'b0;
    step(20);
    chk({vdd_reg_en, regulator_off_safe}, 10'h002);
    pulse(3);
    wait_for(10'h07f, 10'h008, 5);
    chk(safe_n_out, 10'h000);
    // both-off: idle timer restarted first, so sense low alone must not drop it
    misc_init_cfg = 3'h4;
    {bus_activity_in, rst_line_low_in} = 2'h3;
    step(3);
    bus_activity_in = 1'b0;
    wait_for(10'h07f, 10'h040, 60);
    rst_line_low_in = 1'b0;
    step(20);
    chk({vdd_reg_en, regulator_off_safe}, 10'h002);
    wait_for(10'h080, 10'h000, 400);
    {wake_lin_en, lin_activity_in} = 2'h3;
    wait_for(10'h0ff, 10'h084, 10);
    lin_activity_in = 1'b0;
    wait_for(10'h07f, 10'h008, 30);
    misc_init_cfg = 3'h5;
    rst_line_low_in = 1'b1;
    wait_for(10'h07f, 10'h040, 60);
    rst_line_low_in = 1'b0;
    wait_for(10'h080, 10'h000, 10);
    wake_sense_en = 1'b1;
    sense1_in = 1'b1;
    wait_for(10'h0ff, 10'h084, 10);
    wait_for(10'h07f, 10'h008, 30);
    host.send(16'hdd00);
    wait_for(10'h200, 10'h200, 20);
    vdd_low_in = 1'b1;
    wait_for(10'h100, 10'h000, 10);
    chk(st[9:7], 10'h001);
    battery_supply_in = 1'b0;
    wait_for(10'h080, 10'h000, 10);
    {sys_rst, battery_supply_in, vdd_low_in} = 3'h6;
    wd_init_cfg = 8'h01;
    step(3);
    sys_rst = 1'b0;
    wait_for(10'h080, 10'h080, 20);
    battery_por_in = 1'b1;
    wait_for(10'h080, 10'h000, 10);
    chk(battery_fail_flag, 10'h001);
    complete_run();
  end
endmodule : fail_safe_supply_supervisor_bench

// ===== sim/host_link_model.sv
// host side of the command link: 16-bit words, msb first
// assumes the core samples mosi on rising spi_sclk while spi_cs_n is low
`timescale 1ns/1ns
module host_link_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // ----------------------------------------
  // frame task
  // ----------------------------------------
  // clock stands still between frames; released mosi shows the inverse bit
  task send(input logic [15:0] w);
    #7 spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = w[i];
      #15 spi_sclk = 1'b1;
      #15 spi_sclk = 1'b0;
    end
    #15 spi_cs_n = 1'b1;
    spi_mosi = ~w[0];
  endtask : send
endmodule : host_link_model
